// File: verilog/nvpe_ctrl.sv
// Purpose: EEPROM program/erase control, configuration and timebase divider
// Assumes: Nonvolatile store contents arrive as steady inputs; one clock
// Notes:   All state is one struct; register file is an AXI4-Lite slave
//
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module nvpe_ctrl #(
	parameter logic [15:0] PROG_TICKS        = nvpe_pkg::PROG_TICKS,
	parameter logic [15:0] BYTE_ERASE_TICKS  = nvpe_pkg::BYTE_ERASE_TICKS,
	parameter logic [15:0] BLOCK_ERASE_TICKS = nvpe_pkg::BLOCK_ERASE_TICKS,
	parameter logic [15:0] BULK_ERASE_TICKS  = nvpe_pkg::BULK_ERASE_TICKS
) (
	input  wire logic                    core_clk,
	input  wire logic                    resetn,
	input  wire nvpe_pkg::nvpe_axi_req_s axiReq,
	output nvpe_pkg::nvpe_axi_rsp_s      axiRsp,
	input  wire nvpe_pkg::nvpe_arr_wr_s  arrWr,
	input  wire logic                    stopMode,
	input  wire logic [7:0]              nvCfgStore,
	input  wire logic [7:0]              nvDivHStore,
	input  wire logic [7:0]              nvDivLStore,
	output logic                         arrayEnable,
	output logic                         chargePumpOn,
	output logic [15:0]                  latchedAddr,
	output logic [7:0]                   latchedData,
	output logic [1:0]                   opMode,
	output logic                         timebaseTick,
	output logic                         accessRefused
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		nvpe_pkg::nvpe_axi_rsp_s rsp;
		logic                    awHeld;
		logic [7:0]              awAddr;
		logic                    wHeld;
		logic [7:0]              wData;
		logic                    wLane0;
		logic                    loadDone;
		logic [7:0]              ctrl;
		logic [2:0]              spareCfg;
		logic                    security;
		logic [3:0]              blockProtect;
		logic                    divSecD;
		logic [10:0]             divisor;
		logic                    addrValid;
		logic [15:0]             latAddr;
		logic [7:0]              latData;
		nvpe_pkg::nvpe_seq_e     seq;
		logic [10:0]             divCnt;
		logic                    tick;
		logic [15:0]             seqTicks;
		logic                    pump;
		logic                    refused;
		logic                    enable;
	} nvpe_state_s;

	nvpe_state_s stQ;
	nvpe_state_s stD;
	logic        ctrlWrStb;
	logic [7:0]  ctrlWrData;
	logic [15:0] tickLimit;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic validAddr(input logic [15:0] a);
		validAddr = (a >= nvpe_pkg::ARRAY_FIRST && a <= nvpe_pkg::ARRAY_LAST) ||
			a == nvpe_pkg::CFGSTORE_ADDR || a == nvpe_pkg::DIVHSTORE_ADDR ||
			a == nvpe_pkg::DIVLSTORE_ADDR;
	endfunction

	function automatic logic opAllowed(input logic [1:0] mode, input logic [15:0] a,
		input logic sec, input logic [3:0] bp, input logic secd);
		logic byteOp;
		byteOp = (mode == nvpe_pkg::MODE_BYTE_PROG) || (mode == nvpe_pkg::MODE_BYTE_ERASE);
		if (a >= nvpe_pkg::ARRAY_FIRST && a <= nvpe_pkg::ARRAY_LAST) begin
			if (bp[a[8:7]]) begin
				opAllowed = 1'b0;
			end else if (!sec) begin
				opAllowed = byteOp && !(a >= nvpe_pkg::SECURE_FIRST &&
					a <= nvpe_pkg::SECURE_LAST);
			end else begin
				opAllowed = 1'b1;
			end
		end else if (a == nvpe_pkg::CFGSTORE_ADDR) begin
			opAllowed = byteOp;
		end else if (a == nvpe_pkg::DIVHSTORE_ADDR || a == nvpe_pkg::DIVLSTORE_ADDR) begin
			opAllowed = byteOp && secd;
		end else begin
			opAllowed = 1'b0;
		end
	endfunction

	function automatic logic [7:0] readReg(input logic [7:0] ofs, input nvpe_state_s s,
		input logic [7:0] cfgS, input logic [7:0] divHS, input logic [7:0] divLS);
		unique case (ofs)
			nvpe_pkg::CTRL_OFS:      readReg = s.ctrl;
			nvpe_pkg::ARRCFG_OFS:    readReg = {s.spareCfg, s.security, s.blockProtect};
			nvpe_pkg::CFGSTORE_OFS:  readReg = cfgS;
			nvpe_pkg::DIVH_OFS:      readReg = {s.divSecD, 4'h0, s.divisor[10:8]};
			nvpe_pkg::DIVL_OFS:      readReg = s.divisor[7:0];
			nvpe_pkg::DIVHSTORE_OFS: readReg = divHS;
			nvpe_pkg::DIVLSTORE_OFS: readReg = divLS;
			nvpe_pkg::STATUS_OFS:    readReg = {5'h00, s.addrValid, s.seq == nvpe_pkg::SEQ_HALT,
				s.seq != nvpe_pkg::SEQ_IDLE};
			default:                 readReg = 8'h00;
		endcase
	endfunction

	function automatic logic mapped(input logic [7:0] ofs);
		mapped = ofs[1:0] == 2'h0 && ofs <= nvpe_pkg::STATUS_OFS;
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [7:0] d;
		logic       wantPgm;
		d = 8'h00;
		wantPgm = 1'b0;
		stD = stQ;
		ctrlWrStb = 1'b0;
		ctrlWrData = 8'h00;

		unique case (stQ.ctrl[nvpe_pkg::CTRL_ERAS1_BIT:nvpe_pkg::CTRL_ERAS0_BIT])
			nvpe_pkg::MODE_BYTE_PROG:   tickLimit = PROG_TICKS;
			nvpe_pkg::MODE_BYTE_ERASE:  tickLimit = BYTE_ERASE_TICKS;
			nvpe_pkg::MODE_BLOCK_ERASE: tickLimit = BLOCK_ERASE_TICKS;
			nvpe_pkg::MODE_BULK_ERASE:  tickLimit = BULK_ERASE_TICKS;
		endcase

		// Configuration is copied once, right after reset release
		if (!stQ.loadDone) begin
			stD.loadDone = 1'b1;
			stD.spareCfg = nvCfgStore[7:5];
			stD.security = nvCfgStore[nvpe_pkg::CFG_SEC_BIT];
			stD.blockProtect = nvCfgStore[3:0];
			stD.divSecD = nvDivHStore[nvpe_pkg::DIVH_SECD_BIT];
			stD.divisor = {nvDivHStore[2:0], nvDivLStore};
		end

		// AXI write channels, accepted in either order
		if (stQ.rsp.bvalid && axiReq.bready) begin
			stD.rsp.bvalid = 1'b0;
		end
		if (stQ.rsp.awready && axiReq.awvalid) begin
			stD.awHeld = 1'b1;
			stD.awAddr = axiReq.awaddr;
		end
		if (stQ.rsp.wready && axiReq.wvalid) begin
			stD.wHeld = 1'b1;
			stD.wData = axiReq.wdata[7:0];
			stD.wLane0 = axiReq.wstrb[0];
		end
		if (stD.awHeld && stD.wHeld && !stD.rsp.bvalid) begin
			stD.awHeld = 1'b0;
			stD.wHeld = 1'b0;
			stD.rsp.bvalid = 1'b1;
			stD.rsp.bresp = mapped(stD.awAddr) ? nvpe_pkg::RESP_OKAY : nvpe_pkg::RESP_SLVERR;
			d = stD.wData;
			if (stD.wLane0) begin
				unique case (stD.awAddr)
					nvpe_pkg::CTRL_OFS: begin
						ctrlWrStb = 1'b1;
						ctrlWrData = d;
					end
					nvpe_pkg::ARRCFG_OFS: begin
						stD.spareCfg = d[7:5];
					end
					nvpe_pkg::DIVH_OFS: begin
						if (!stQ.ctrl[nvpe_pkg::CTRL_LATCH_BIT] && stQ.divSecD) begin
							stD.divSecD = d[nvpe_pkg::DIVH_SECD_BIT];
							stD.divisor[10:8] = d[2:0];
						end
					end
					nvpe_pkg::DIVL_OFS: begin
						if (!stQ.ctrl[nvpe_pkg::CTRL_LATCH_BIT] && stQ.divSecD) begin
							stD.divisor[7:0] = d;
						end
					end
					default: begin
					end
				endcase
			end
		end

		// Control register write
		if (ctrlWrStb) begin
			stD.ctrl[nvpe_pkg::CTRL_SPARE_BIT] = ctrlWrData[nvpe_pkg::CTRL_SPARE_BIT];
			stD.ctrl[nvpe_pkg::CTRL_PDOWN_BIT] = ctrlWrData[nvpe_pkg::CTRL_PDOWN_BIT];
			stD.ctrl[nvpe_pkg::CTRL_AUTO_BIT] = ctrlWrData[nvpe_pkg::CTRL_AUTO_BIT];
			// Mode stays put while a cycle runs so the timer limit cannot jump
			if (!stQ.ctrl[nvpe_pkg::CTRL_PGM_BIT]) begin
				stD.ctrl[4:3] = ctrlWrData[4:3];
			end
			wantPgm = ctrlWrData[nvpe_pkg::CTRL_PGM_BIT];
			if (!wantPgm) begin
				stD.ctrl[nvpe_pkg::CTRL_PGM_BIT] = 1'b0;
			end else if (stQ.ctrl[nvpe_pkg::CTRL_LATCH_BIT] && stQ.addrValid &&
				opAllowed(stQ.ctrl[4:3], stQ.latAddr, stQ.security, stQ.blockProtect,
				stQ.divSecD)) begin
				stD.ctrl[nvpe_pkg::CTRL_PGM_BIT] = 1'b1;
			end
			if (ctrlWrData[nvpe_pkg::CTRL_LATCH_BIT]) begin
				stD.ctrl[nvpe_pkg::CTRL_LATCH_BIT] = 1'b1;
			end else if (!stQ.ctrl[nvpe_pkg::CTRL_PGM_BIT] &&
				!stD.ctrl[nvpe_pkg::CTRL_PGM_BIT]) begin
				stD.ctrl[nvpe_pkg::CTRL_LATCH_BIT] = 1'b0;
				stD.addrValid = 1'b0;
			end
		end

		// Array bus capture, last valid write wins
		if (stQ.ctrl[nvpe_pkg::CTRL_LATCH_BIT] && !stQ.ctrl[nvpe_pkg::CTRL_PGM_BIT] &&
			arrWr.en && validAddr(arrWr.addr)) begin
			stD.latAddr = arrWr.addr;
			stD.latData = arrWr.data;
			stD.addrValid = 1'b1;
		end

		// Timebase divider; wait mode does not gate it
		stD.tick = 1'b0;
		if (stQ.divisor == 11'h000 || stopMode || !stQ.enable) begin
			stD.divCnt = 11'h000;
		end else if (stQ.divCnt >= stQ.divisor - 11'h001) begin
			stD.divCnt = 11'h000;
			stD.tick = 1'b1;
		end else begin
			stD.divCnt = stQ.divCnt + 11'h001;
		end

		// Program/erase sequence
		unique case (stQ.seq)
			nvpe_pkg::SEQ_IDLE: begin
				stD.seqTicks = 16'h0000;
				if (stD.ctrl[nvpe_pkg::CTRL_PGM_BIT]) begin
					stD.seq = nvpe_pkg::SEQ_RUN;
				end
			end
			nvpe_pkg::SEQ_RUN: begin
				if (!stD.ctrl[nvpe_pkg::CTRL_PGM_BIT]) begin
					stD.seq = nvpe_pkg::SEQ_IDLE;
				end else if (stopMode) begin
					stD.seq = nvpe_pkg::SEQ_HALT;
				end else if (stQ.tick) begin
					stD.seqTicks = stQ.seqTicks + 16'h0001;
					if (stQ.ctrl[nvpe_pkg::CTRL_AUTO_BIT] &&
						stQ.seqTicks + 16'h0001 >= tickLimit) begin
						stD.ctrl[nvpe_pkg::CTRL_PGM_BIT] = 1'b0;
						stD.seq = nvpe_pkg::SEQ_IDLE;
					end
				end
			end
			nvpe_pkg::SEQ_HALT: begin
				// Restart from zero: partial pulse time is not trusted
				stD.seqTicks = 16'h0000;
				if (!stD.ctrl[nvpe_pkg::CTRL_PGM_BIT]) begin
					stD.seq = nvpe_pkg::SEQ_IDLE;
				end else if (!stopMode) begin
					stD.seq = nvpe_pkg::SEQ_RUN;
				end
			end
			default: stD.seq = nvpe_pkg::SEQ_IDLE;
		endcase

		// Stop during voltage decay ends the sequence outright
		if (stopMode && !stQ.ctrl[nvpe_pkg::CTRL_PGM_BIT] &&
			!stD.ctrl[nvpe_pkg::CTRL_PGM_BIT] &&
			stQ.ctrl[nvpe_pkg::CTRL_LATCH_BIT]) begin
			stD.ctrl[nvpe_pkg::CTRL_LATCH_BIT] = 1'b0;
			stD.addrValid = 1'b0;
		end

		stD.ctrl[6] = 1'b0;
		stD.pump = stD.ctrl[nvpe_pkg::CTRL_PGM_BIT] && stD.ctrl[nvpe_pkg::CTRL_LATCH_BIT] &&
			stD.seq == nvpe_pkg::SEQ_RUN && !stopMode;
		stD.refused = stD.seq != nvpe_pkg::SEQ_IDLE;
		stD.enable = !stD.ctrl[nvpe_pkg::CTRL_PDOWN_BIT];

		// AXI read channel
		if (stQ.rsp.rvalid && axiReq.rready) begin
			stD.rsp.rvalid = 1'b0;
		end
		if (stQ.rsp.arready && axiReq.arvalid) begin
			stD.rsp.rvalid = 1'b1;
			stD.rsp.rdata = {24'h000000, readReg(axiReq.araddr, stQ, nvCfgStore, nvDivHStore,
				nvDivLStore)};
			stD.rsp.rresp = mapped(axiReq.araddr) ? nvpe_pkg::RESP_OKAY : nvpe_pkg::RESP_SLVERR;
		end
		stD.rsp.awready = !stD.awHeld && !stD.rsp.bvalid;
		stD.rsp.wready = !stD.wHeld && !stD.rsp.bvalid;
		stD.rsp.arready = !stD.rsp.rvalid;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			stQ <= '0;
			stQ.ctrl <= nvpe_pkg::CTRL_RESET;
			stQ.seq <= nvpe_pkg::SEQ_IDLE;
		end else begin
			stQ <= stD;
		end
	end

	assign axiRsp = stQ.rsp;
	assign arrayEnable = stQ.enable;
	assign chargePumpOn = stQ.pump;
	assign latchedAddr = stQ.latAddr;
	assign latchedData = stQ.latData;
	assign opMode = stQ.ctrl[4:3];
	assign timebaseTick = stQ.tick;
	assign accessRefused = stQ.refused;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	sequence zeroCtrlWrite;
		ctrlWrStb && ctrlWrData[nvpe_pkg::CTRL_PGM_BIT] == 1'b0 &&
			ctrlWrData[nvpe_pkg::CTRL_LATCH_BIT] == 1'b0 && stQ.ctrl[nvpe_pkg::CTRL_PGM_BIT];
	endsequence
	sequence autoFinish;
		stQ.seq == nvpe_pkg::SEQ_RUN && !stopMode && stQ.tick &&
			stQ.ctrl[nvpe_pkg::CTRL_AUTO_BIT] && stQ.seqTicks + 16'h0001 >= tickLimit;
	endsequence

	chk_pgm_needs_latch: assert property ($rose(stQ.ctrl[nvpe_pkg::CTRL_PGM_BIT]) |->
		$past(stQ.ctrl[nvpe_pkg::CTRL_LATCH_BIT] && stQ.addrValid))
		else $error("program enable set without valid latch");
	chk_latch_held: assert property (stQ.ctrl[nvpe_pkg::CTRL_PGM_BIT] |->
		stQ.ctrl[nvpe_pkg::CTRL_LATCH_BIT])
		else $error("latch cleared while programming");
	chk_zero_write: assert property (zeroCtrlWrite |=>
		!stQ.ctrl[nvpe_pkg::CTRL_PGM_BIT] && stQ.ctrl[nvpe_pkg::CTRL_LATCH_BIT])
		else $error("double clear did not keep latch");
	chk_auto_clear: assert property (autoFinish |=>
		!stQ.ctrl[nvpe_pkg::CTRL_PGM_BIT] && stQ.seq == nvpe_pkg::SEQ_IDLE)
		else $error("self-terminate did not clear program enable");
	chk_stop_pump: assert property (stopMode |=> !chargePumpOn)
		else $error("pump on during stop");
	chk_halt_refuse: assert property (stQ.seq == nvpe_pkg::SEQ_HALT && !stopMode && !ctrlWrStb &&
		stQ.ctrl[nvpe_pkg::CTRL_PGM_BIT] |=> stQ.seq == nvpe_pkg::SEQ_RUN && accessRefused)
		else $error("sequence did not restart after stop");
	chk_cfg_readonly: assert property (stQ.loadDone |=>
		$stable(stQ.security) && $stable(stQ.blockProtect))
		else $error("protection bits changed after load");
	chk_div_lock: assert property (stQ.loadDone && !stQ.divSecD |=>
		$stable(stQ.divisor) && !stQ.divSecD)
		else $error("divider changed while locked");
	chk_tick_period: assert property (timebaseTick |->
		$past(stQ.divCnt) == $past(stQ.divisor) - 11'h001)
		else $error("tick not at divisor count");
	chk_power_down: assert property (ctrlWrStb && stQ.rsp.bvalid == 1'b0 |-> ##2
		arrayEnable == !$past(stQ.ctrl[nvpe_pkg::CTRL_PDOWN_BIT]))
		else $error("array enable does not follow power-down bit");

endmodule

// File: common/nvpe_pkg.sv
// Purpose: Shared constants and types for the EEPROM program/erase controller
// Assumes: AXI4-Lite register access, 8-bit register data in the low byte lane
// Notes:   Register map, field positions, address ranges, modes, timing and bus types
package nvpe_pkg;

	// ------------------------------------------------------------
	// Register map (byte offsets)
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS       = 8'h00;
	localparam logic [7:0] ARRCFG_OFS     = 8'h04;
	localparam logic [7:0] CFGSTORE_OFS   = 8'h08;
	localparam logic [7:0] DIVH_OFS       = 8'h0C;
	localparam logic [7:0] DIVL_OFS       = 8'h10;
	localparam logic [7:0] DIVHSTORE_OFS  = 8'h14;
	localparam logic [7:0] DIVLSTORE_OFS  = 8'h18;
	localparam logic [7:0] STATUS_OFS     = 8'h1C;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTRL_SPARE_BIT  = 7;
	localparam int CTRL_PDOWN_BIT  = 5;
	localparam int CTRL_ERAS1_BIT  = 4;
	localparam int CTRL_ERAS0_BIT  = 3;
	localparam int CTRL_LATCH_BIT  = 2;
	localparam int CTRL_AUTO_BIT   = 1;
	localparam int CTRL_PGM_BIT    = 0;
	localparam int CFG_SEC_BIT     = 4;
	localparam int DIVH_SECD_BIT   = 7;

	// ------------------------------------------------------------
	// Reset values and address ranges
	// ------------------------------------------------------------
	localparam logic [7:0]  CTRL_RESET     = 8'h00;
	localparam logic [15:0] ARRAY_FIRST    = 16'h0800;
	localparam logic [15:0] ARRAY_LAST     = 16'h09FF;
	localparam logic [15:0] SECURE_FIRST   = 16'h08F0;
	localparam logic [15:0] SECURE_LAST    = 16'h08FF;
	localparam logic [15:0] CFGSTORE_ADDR  = 16'hFE10;
	localparam logic [15:0] DIVHSTORE_ADDR = 16'hFE11;
	localparam logic [15:0] DIVLSTORE_ADDR = 16'hFE12;

	// ------------------------------------------------------------
	// Modes, responses and timing
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_BYTE_PROG  = 2'h0;
	localparam logic [1:0] MODE_BYTE_ERASE = 2'h1;
	localparam logic [1:0] MODE_BLOCK_ERASE = 2'h2;
	localparam logic [1:0] MODE_BULK_ERASE = 2'h3;
	localparam logic [1:0] RESP_OKAY       = 2'h0;
	localparam logic [1:0] RESP_SLVERR     = 2'h2;
	localparam int         TICK_US         = 35;
	localparam logic [15:0] PROG_TICKS     = 16'h0100;
	localparam logic [15:0] BYTE_ERASE_TICKS  = 16'h0100;
	localparam logic [15:0] BLOCK_ERASE_TICKS = 16'h0100;
	localparam logic [15:0] BULK_ERASE_TICKS  = 16'h0100;

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_HALT} nvpe_seq_e;

	typedef struct packed {
		logic       awvalid;
		logic [7:0] awaddr;
		logic       wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic       bready;
		logic       arvalid;
		logic [7:0] araddr;
		logic       rready;
	} nvpe_axi_req_s;

	typedef struct packed {
		logic       awready;
		logic       wready;
		logic       bvalid;
		logic [1:0] bresp;
		logic       arready;
		logic       rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} nvpe_axi_rsp_s;

	typedef struct packed {
		logic       en;
		logic [15:0] addr;
		logic [7:0] data;
	} nvpe_arr_wr_s;

endpackage

// File: testbench/nvpe_cpu_model.sv
// Purpose: CPU-side partner driving the array write bus and stop mode
// Assumes: Every change is launched right after a rising edge of core_clk
// Notes:   An idle bus shows the inverse of the last value, never a stale copy
`timescale 1ns/1ps
module nvpe_cpu_model (
	input  wire logic              core_clk,
	output nvpe_pkg::nvpe_arr_wr_s arrWr,
	output logic                   stopMode
);
	initial begin
		arrWr = '0;
		stopMode = 1'b0;
	end
	// One-cycle strobe, as a single store cycle of the core
	task automatic arr_write(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		arrWr <= '{en: 1'b1, addr: a, data: d};
		@(posedge core_clk);
		arrWr <= '{en: 1'b0, addr: ~a, data: ~d};
	endtask
	task automatic set_stop(input logic s);
		@(posedge core_clk);
		stopMode <= s;
	endtask
endmodule

// File: testbench/nvpe_ctrl_test.sv
// Purpose: Self-checking bench for the EEPROM program/erase controller
// Assumes: Tick limits shortened to 4, divisor 4 from the stores
// Notes:   Register traffic over AXI4-Lite; stores held as steady levels
`timescale 1ns/1ps
module nvpe_ctrl_test;
	localparam logic [15:0] TK = 16'h0004;
	logic                    core_clk;
	logic                    resetn;
	nvpe_pkg::nvpe_axi_req_s req;
	nvpe_pkg::nvpe_axi_rsp_s rsp;
	nvpe_pkg::nvpe_arr_wr_s  arrWr;
	logic                    stopMode;
	logic [7:0]              cfgS;
	logic [7:0]              divHS;
	logic [7:0]              divLS;
	logic                    arrEn;
	logic                    pump;
	logic [15:0]             lAddr;
	logic [7:0]              lData;
	logic [1:0]              mode;
	logic                    tick;
	logic                    refused;
	logic [31:0]             rd;
	logic [1:0]              rs;
	int                      fail_count = 0;
	int                      cmp_count = 0;
	int                      n;

	nvpe_ctrl #(.PROG_TICKS(TK), .BYTE_ERASE_TICKS(TK), .BLOCK_ERASE_TICKS(TK),
		.BULK_ERASE_TICKS(TK)) u_nvpe_ctrl (.core_clk(core_clk), .resetn(resetn),
		.axiReq(req), .axiRsp(rsp), .arrWr(arrWr), .stopMode(stopMode),
		.nvCfgStore(cfgS), .nvDivHStore(divHS), .nvDivLStore(divLS),
		.arrayEnable(arrEn), .chargePumpOn(pump), .latchedAddr(lAddr),
		.latchedData(lData), .opMode(mode), .timebaseTick(tick), .accessRefused(refused));
	nvpe_cpu_model u_nvpe_cpu_model (.core_clk(core_clk), .arrWr(arrWr), .stopMode(stopMode));

	initial core_clk = 1'b0;
	always #2.5 core_clk = ~core_clk;

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic stop_test;
		$display("fail_count=%0d cmp_count=%0d", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask
	// A spent bound ends the run rather than hanging it
	task automatic guard(input int k);
		if (k >= 100) begin
			$display("CHECK FAILED wait bound expected done seen hang");
			fail_count++;
			stop_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] er = nvpe_pkg::RESP_OKAY);
		int k;
		k = 0;
		@(posedge core_clk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= {24'h000000, d};
		req.wstrb <= 4'hF;
		req.bready <= 1'b1;
		do begin
			@(posedge core_clk);
			k++;
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (!rsp.bvalid && k < 100);
		guard(k);
		req.bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, rsp.bresp});
	endtask
	task automatic rdr(input logic [7:0] a);
		int k;
		k = 0;
		@(posedge core_clk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do begin
			@(posedge core_clk);
			k++;
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (!rsp.rvalid && k < 100);
		guard(k);
		req.rready <= 1'b0;
		rd = rsp.rdata;
		rs = rsp.rresp;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
		rdr(a);
		chk(nm, {24'h000000, e}, rd);
	endtask
	task automatic poll_pgm;
		n = 0;
		do begin
			rdr(nvpe_pkg::CTRL_OFS);
			n++;
		end while (rd[0] && n < 100);
		guard(n);
	endtask
	// Mode, latched write, program request, then a double clear
	task automatic try_pgm(input logic [1:0] m, input logic [15:0] a, input logic ok);
		wr(nvpe_pkg::CTRL_OFS, {3'h0, m, 3'h4});
		u_nvpe_cpu_model.arr_write(a, 8'h5A);
		wr(nvpe_pkg::CTRL_OFS, {3'h0, m, 3'h5});
		repeat (3) @(posedge core_clk);
		chk("pump", {31'h0, ok}, {31'h0, pump});
		if (ok) chk("opMode", {30'h0, m}, {30'h0, mode});
		wr(nvpe_pkg::CTRL_OFS, 8'h00);
		rdc(nvpe_pkg::CTRL_OFS, ok ? {3'h0, m, 3'h4} : 8'h00, "ctrl");
		wr(nvpe_pkg::CTRL_OFS, 8'h00);
	endtask
	task automatic do_reset;
		resetn <= 1'b0;
		repeat (6) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (2) @(posedge core_clk);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		req = '0;
		resetn = 1'b0;
		cfgS = 8'hF0;
		divHS = 8'h80;
		divLS = 8'h04;
		do_reset();
		chk("arrayEnable", 32'h1, {31'h0, arrEn});
		rdc(nvpe_pkg::CTRL_OFS, 8'h00, "ctrl");
		rdc(nvpe_pkg::ARRCFG_OFS, 8'hF0, "arrcfg");
		rdc(nvpe_pkg::DIVH_OFS, 8'h80, "divh");
		rdc(nvpe_pkg::DIVL_OFS, 8'h04, "divl");
		rdc(nvpe_pkg::CFGSTORE_OFS, 8'hF0, "cfgstore");
		rdc(nvpe_pkg::DIVHSTORE_OFS, 8'h80, "divhstore");
		rdc(nvpe_pkg::DIVLSTORE_OFS, 8'h04, "divlstore");
		rdr(8'h20);
		chk("rresp", {30'h0, nvpe_pkg::RESP_SLVERR}, {30'h0, rs});
		wr(8'h20, 8'h00, nvpe_pkg::RESP_SLVERR);
		wr(nvpe_pkg::CTRL_OFS, 8'h80);
		rdc(nvpe_pkg::CTRL_OFS, 8'h80, "ctrl");
		wr(nvpe_pkg::ARRCFG_OFS, 8'h0F);
		rdc(nvpe_pkg::ARRCFG_OFS, 8'h10, "arrcfg");
		wr(nvpe_pkg::CTRL_OFS, 8'h20);
		repeat (2) @(posedge core_clk);
		chk("arrayEnable", 32'h0, {31'h0, arrEn});
		wr(nvpe_pkg::CTRL_OFS, 8'h01);
		rdc(nvpe_pkg::CTRL_OFS, 8'h00, "ctrl");
		wr(nvpe_pkg::CTRL_OFS, 8'h04);
		wr(nvpe_pkg::CTRL_OFS, 8'h05);
		rdc(nvpe_pkg::CTRL_OFS, 8'h04, "ctrl");
		u_nvpe_cpu_model.arr_write(16'h0810, 8'h33);
		u_nvpe_cpu_model.arr_write(16'h0820, 8'h44);
		u_nvpe_cpu_model.arr_write(16'h1000, 8'h77);
		@(posedge core_clk);
		chk("latchedAddr", 32'h0820, {16'h0, lAddr});
		chk("latchedData", 32'h44, {24'h0, lData});
		rdc(nvpe_pkg::STATUS_OFS, 8'h04, "status");
		wr(nvpe_pkg::CTRL_OFS, 8'h03);
		repeat (3) @(posedge core_clk);
		chk("pump", 32'h1, {31'h0, pump});
		chk("refused", 32'h1, {31'h0, refused});
		poll_pgm();
		chk("ctrl", 32'h06, rd);
		chk("pump", 32'h0, {31'h0, pump});
		wr(nvpe_pkg::CTRL_OFS, 8'h00);
		n = 0;
		while (!tick && n < 100) begin
			@(posedge core_clk);
			n++;
		end
		guard(n);
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (!tick && n < 100);
		chk("tickPeriod", 32'h4, n);
		// Halt in stop, restart after it
		wr(nvpe_pkg::CTRL_OFS, 8'h06);
		u_nvpe_cpu_model.arr_write(16'h0900, 8'h12);
		wr(nvpe_pkg::CTRL_OFS, 8'h07);
		u_nvpe_cpu_model.set_stop(1'b1);
		repeat (40) @(posedge core_clk);
		chk("pump", 32'h0, {31'h0, pump});
		chk("refused", 32'h1, {31'h0, refused});
		rdc(nvpe_pkg::STATUS_OFS, 8'h07, "status");
		u_nvpe_cpu_model.set_stop(1'b0);
		repeat (3) @(posedge core_clk);
		chk("pump", 32'h1, {31'h0, pump});
		poll_pgm();
		chk("refused", 32'h0, {31'h0, refused});
		u_nvpe_cpu_model.set_stop(1'b1);
		repeat (3) @(posedge core_clk);
		u_nvpe_cpu_model.set_stop(1'b0);
		rdc(nvpe_pkg::CTRL_OFS, 8'h02, "ctrl");
		wr(nvpe_pkg::DIVL_OFS, 8'h06);
		rdc(nvpe_pkg::DIVL_OFS, 8'h06, "divl");
		wr(nvpe_pkg::CTRL_OFS, 8'h04);
		wr(nvpe_pkg::DIVL_OFS, 8'h09);
		rdc(nvpe_pkg::DIVL_OFS, 8'h06, "divl");
		wr(nvpe_pkg::CTRL_OFS, 8'h00);
		for (int i = 0; i < 4; i++) try_pgm(2'(i), 16'h0810, 1'b1);
		try_pgm(nvpe_pkg::MODE_BYTE_PROG, nvpe_pkg::CFGSTORE_ADDR, 1'b1);
		try_pgm(nvpe_pkg::MODE_BYTE_PROG, nvpe_pkg::DIVLSTORE_ADDR, 1'b1);
		// Security armed, block 0 protected, divider locked
		cfgS <= 8'h01;
		divHS <= 8'h00;
		do_reset();
		rdc(nvpe_pkg::ARRCFG_OFS, 8'h01, "arrcfg");
		wr(nvpe_pkg::ARRCFG_OFS, 8'h11);
		rdc(nvpe_pkg::ARRCFG_OFS, 8'h01, "arrcfg");
		rdc(nvpe_pkg::DIVH_OFS, 8'h00, "divh");
		wr(nvpe_pkg::DIVH_OFS, 8'h80);
		rdc(nvpe_pkg::DIVH_OFS, 8'h00, "divh");
		wr(nvpe_pkg::DIVL_OFS, 8'h09);
		rdc(nvpe_pkg::DIVL_OFS, 8'h04, "divl");
		try_pgm(nvpe_pkg::MODE_BYTE_PROG, 16'h0810, 1'b0);
		try_pgm(nvpe_pkg::MODE_BYTE_PROG, 16'h08F5, 1'b0);
		try_pgm(nvpe_pkg::MODE_BYTE_ERASE, 16'h0880, 1'b1);
		try_pgm(nvpe_pkg::MODE_BLOCK_ERASE, 16'h0980, 1'b0);
		try_pgm(nvpe_pkg::MODE_BYTE_PROG, 16'h0900, 1'b1);
		try_pgm(nvpe_pkg::MODE_BYTE_PROG, nvpe_pkg::DIVHSTORE_ADDR, 1'b0);
		stop_test();
	end
endmodule
